// ==== hw/sgw_core_port.sv ====
`timescale 1ns/1ps
`include "sgw_params.svh"

module sgw_core_port #(
  parameter int N_THREADS = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Link to the hub
  sgw_link_if.core link,
  // Thread side status
  output logic [N_THREADS-1:0] done_flags
);

  localparam int TW = (N_THREADS > 1) ? $clog2(N_THREADS) : 1;

  logic [31:0] payload;
  logic [31:0] last_ctrl;
  logic err_flag;
  logic [31:0] trf [N_THREADS];
  logic [31:0] rd_data;

  // ==========================================================
  // Address decode
  // ==========================================================
  wire setup_acc = psel & penable & ~pready;
  wire commit = psel & penable & pready;
  wire wr_commit = commit & pwrite;
  wire hit_ctrl = (paddr == `SGW_REG_CTRL);
  wire hit_payload = (paddr == `SGW_REG_PAYLOAD);
  wire hit_status = (paddr == `SGW_REG_STATUS);
  wire hit_done = (paddr == `SGW_REG_DONE);
  wire [3:0] trf_idx = paddr[5:2];
  wire hit_trf = (paddr[11:6] == `SGW_TRF_PAGE) &&
                 (int'(trf_idx) < N_THREADS);
  wire unmapped = ~(hit_ctrl | hit_payload | hit_status | hit_done |
                    hit_trf);

  wire [2:0] kind_w = pwdata[2:0];
  wire kind_wait = (kind_w == 3'(sgw_pkg::msg_wait));
  wire kind_bar = (kind_w == 3'(sgw_pkg::msg_barrier));
  // Illegal timeouts are refused here and never reach the hub.
  wire wait_bad = kind_wait &&
                  (payload[`SGW_TMO_MSB:0] < `SGW_TMO_MIN); // RQ18
  wire ctrl_refuse = pwrite & hit_ctrl & (link.msg_valid | wait_bad);
  wire launch = wr_commit & hit_ctrl & ~pslverr;
  wire need_rlen = (kind_bar & payload[`SGW_PRED_BIT]) | kind_wait;

  always_comb begin
    rd_data = '0;
    if (hit_ctrl) begin
      rd_data = last_ctrl;
    end else if (hit_payload) begin
      rd_data = payload;
    end else if (hit_status) begin
      rd_data[`SGW_ST_BUSY] = link.msg_valid;
      rd_data[`SGW_ST_ERR] = err_flag;
    end else if (hit_done) begin
      rd_data[N_THREADS-1:0] = done_flags;
    end else if (hit_trf) begin
      rd_data = trf[trf_idx[TW-1:0]];
    end
  end

  // ==========================================================
  // APB answer: one wait state, write applied on the ready edge
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_acc;
      if (setup_acc) begin
        prdata <= pwrite ? '0 : rd_data;
        pslverr <= unmapped | ctrl_refuse;
      end else if (commit) begin
        pslverr <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Software registers and message launch
  // ==========================================================
  wire err_clr = wr_commit & hit_status & pwdata[`SGW_ST_ERR];
  wire err_set = commit & pslverr & pwrite & hit_ctrl;
  wire [N_THREADS-1:0] done_clr = (wr_commit & hit_done) ?
                                  pwdata[N_THREADS-1:0] : '0;
  wire [N_THREADS-1:0] done_set = (link.wb_valid & link.wb_done) ?
                                  link.wb_threads : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      payload <= '0;
      last_ctrl <= '0;
      err_flag <= 1'b0;
      done_flags <= '0;
      link.msg_valid <= 1'b0;
      link.msg_kind <= sgw_pkg::msg_barrier;
      link.msg_thread <= '0;
      link.msg_dw0 <= '0;
      link.msg_mask <= '0;
      link.msg_rlen <= `SGW_RLEN_NONE;
    end else begin
      if (wr_commit && hit_payload) begin
        payload <= pwdata;
      end
      err_flag <= (err_flag & ~err_clr) | err_set;
      done_flags <= (done_flags & ~done_clr) | done_set;
      if (launch) begin
        last_ctrl <= pwdata;
        link.msg_valid <= 1'b1;
        link.msg_kind <= sgw_pkg::sgw_msg_e'(kind_w);
        link.msg_thread <= pwdata[`SGW_CTRL_THR_LSB +: TW];
        link.msg_dw0 <= payload;
        link.msg_mask <= pwdata[`SGW_CTRL_MASK_LSB +: `SGW_MASK_W];
        link.msg_rlen <= need_rlen ? `SGW_RLEN_ONE
                                   : `SGW_RLEN_NONE; // RQ4
      end else if (link.msg_valid && link.msg_ready) begin
        link.msg_valid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Thread register file image
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N_THREADS; i++) begin
        trf[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N_THREADS; i++) begin
        if (link.wb_valid && link.wb_threads[i] && link.wb_write) begin
          trf[i][`SGW_WB_W-1:0] <= link.wb_data; // RQ5
        end else if (wr_commit && hit_trf &&
                     (int'(trf_idx) == i)) begin
          trf[i] <= pwdata;
        end
      end
    end
  end

endmodule : sgw_core_port

// ==== hw/sgw_hub.sv ====
`timescale 1ns/1ps
`include "sgw_params.svh"
// Notes on behaviour
// (RQ1) Completed barrier flags every arrived thread.
// (RQ2) No return byte on barrier completion.
// (RQ3) Sum writeback only for predicated barriers.
// (RQ4) Predicated barrier requests declare length one.
// (RQ5) Upper dword bits and dwords 1-7 untouched.
// (RQ6) Sum is total of all predicate masks.
// (RQ7) Unpredicated barrier writes no sum dword.
// (RQ8) Software tests sum for OR and AND.
// (RQ9) Watch records later events for thread.
// (RQ10) Watch alone gives no writeback.
// (RQ11) One watched number per thread, replaced.
// (RQ12) New watch clears old recorded event.
// (RQ13) Event number in bits 23:0 only.
// (RQ14) Wait answers on event or at once.
// (RQ15) Timeout expiry still sends the writeback.
// (RQ16) Preemption times out every outstanding wait.
// (RQ17) Timeout in bits 9:0, 1024-clock units.
// (RQ18) Timeout values zero and one illegal.
// (RQ19) Wait short by at most one unit.
// (RQ20) Software confirms events through atomic memory.
// (RQ21) Writeback bit 0 tells event or timeout.
// (RQ22) Raised event reaches all watchers and waiters.
// (RQ23) Thread exit drops its event watch.
// (RQ24) Timer starts on wait, stops on writeback.

module sgw_hub #(
  parameter int N_THREADS = 8,
  parameter int TICK_CYCLES = `SGW_TICK_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link to the execution cores
  sgw_link_if.hub link,
  // Engine side
  input wire logic preempt,
  output logic [N_THREADS-1:0] waiting,
  output logic [N_THREADS-1:0] watching
);

  localparam int TW = (N_THREADS > 1) ? $clog2(N_THREADS) : 1;
  localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam int MW = `SGW_MASK_W;
  localparam int SW = `SGW_WB_W;

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [N_THREADS-1:0] thread_bit(
    input logic [TW-1:0] id
  );
    thread_bit = '0;
    thread_bit[id] = 1'b1;
  endfunction : thread_bit

  function automatic logic [SW-1:0] mask_count(
    input logic [MW-1:0] m
  );
    mask_count = '0;
    for (int i = 0; i < MW; i++) begin
      mask_count = mask_count + SW'(m[i]);
    end
  endfunction : mask_count

  // ==========================================================
  // Message decode
  // ==========================================================
  logic [N_THREADS-1:0] recorded;
  logic [N_THREADS-1:0] pre_hit;
  logic [N_THREADS-1:0] expired;
  logic [`SGW_EVT_MSB:0] watch_num [N_THREADS];
  logic [6:0] bar_cnt;
  logic [6:0] bar_limit;
  logic [SW-1:0] bar_sum;
  logic [N_THREADS-1:0] bar_arrived;
  logic [PW-1:0] presc;

  wire take = link.msg_valid & link.msg_ready;
  wire [N_THREADS-1:0] who = take ? thread_bit(link.msg_thread) : '0;
  wire is_bar = (link.msg_kind == sgw_pkg::msg_barrier);
  wire is_watch = (link.msg_kind == sgw_pkg::msg_watch);
  wire is_wait = (link.msg_kind == sgw_pkg::msg_wait);
  wire is_raise = (link.msg_kind == sgw_pkg::msg_raise);
  wire is_drop = (link.msg_kind == sgw_pkg::msg_unwatch) ||
                 (link.msg_kind == sgw_pkg::msg_exit);
  wire is_exit = (link.msg_kind == sgw_pkg::msg_exit);
  // Upper dword bits and the other dwords are never looked at.
  wire [`SGW_EVT_MSB:0] evt_in = link.msg_dw0[`SGW_EVT_MSB:0]; // RQ13
  wire [`SGW_TMO_MSB:0] tmo_in = link.msg_dw0[`SGW_TMO_MSB:0]; // RQ17

  // ==========================================================
  // Barrier
  // ==========================================================
  wire bar_pred = link.msg_dw0[`SGW_PRED_BIT];
  wire cnt_en = link.msg_dw0[`SGW_CNTEN_BIT];
  wire [6:0] cnt_field = link.msg_dw0[`SGW_CNT_MSB:`SGW_CNT_LSB];
  wire [6:0] limit_now = cnt_en ? cnt_field : bar_limit;
  wire [6:0] cnt_now = bar_cnt + 7'h01;
  wire bar_take = take & is_bar;
  wire bar_fire = bar_take & (cnt_now >= limit_now); // RQ1
  wire [SW-1:0] sum_now = bar_sum + mask_count(link.msg_mask); // RQ6

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bar_cnt <= '0;
      bar_limit <= `SGW_LIMIT_RST;
      bar_sum <= '0;
      bar_arrived <= '0;
    end else if (bar_take) begin
      bar_limit <= limit_now;
      bar_cnt <= bar_fire ? 7'h00 : cnt_now;
      bar_sum <= bar_fire ? '0 : sum_now;
      bar_arrived <= bar_fire ? '0 : (bar_arrived | who);
    end
  end

  // ==========================================================
  // Timeout tick and per-thread timers
  // ==========================================================
  wire tick = (presc == PW'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= '0;
    end else begin
      presc <= tick ? '0 : presc + PW'(1);
    end
  end

  wire [N_THREADS-1:0] wait_start = (take & is_wait) ? (who & ~waiting)
                                                     : '0;
  wire [N_THREADS-1:0] watch_set = is_watch ? who : '0;
  wire [N_THREADS-1:0] watch_drop = is_drop ? who : '0;
  wire [N_THREADS-1:0] exit_vec = is_exit ? who : '0;
  wire [N_THREADS-1:0] pre_now = preempt ? waiting : '0;
  wire [N_THREADS-1:0] hit;
  logic [N_THREADS-1:0] sent;

  genvar g;
  generate
    for (g = 0; g < N_THREADS; g++) begin : g_thr
      assign hit[g] = take & is_raise & watching[g] &
                      (watch_num[g] == evt_in); // RQ22

      sgw_wait_timer #(
        .W(`SGW_TMO_MSB + 1)
      ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .start(wait_start[g]), // RQ24
        .cancel(sent[g]), // RQ24
        .units(tmo_in),
        .expired(expired[g]) // RQ19
      );
    end
  endgenerate

  // ==========================================================
  // Writeback selection
  // ==========================================================
  // A barrier completion owns the writeback port for its cycle; event
  // answers are levels and simply go out one cycle later.
  wire [N_THREADS-1:0] occ_set = waiting & recorded; // RQ14
  wire [N_THREADS-1:0] tmo_set = waiting & (expired | pre_hit | pre_now);
  wire send_occ = ~bar_fire & (|occ_set);
  wire send_tmo = ~bar_fire & ~send_occ & (|tmo_set); // RQ15 RQ16
  assign sent = send_occ ? occ_set : (send_tmo ? tmo_set : '0);

  wire next_wb_valid = bar_fire | send_occ | send_tmo;
  wire [N_THREADS-1:0] next_wb_threads = bar_fire ? (bar_arrived | who)
                                                  : sent; // RQ1
  // Only the low half of dword zero is carried at all.
  wire next_wb_write = bar_fire ? bar_pred : next_wb_valid; // RQ3 RQ7 RQ5
  wire [SW-1:0] next_wb_data = bar_fire ? (bar_pred ? sum_now
                                                    : `SGW_WB_NONE)
                             : (send_occ ? `SGW_WB_OCC
                                         : `SGW_WB_NONE); // RQ21 RQ2

  // ==========================================================
  // Event tracking
  // ==========================================================
  wire [N_THREADS-1:0] consumed = send_occ ? occ_set : '0;
  // A raise that lands while an old record is consumed still sticks.
  wire [N_THREADS-1:0] next_recorded =
    (recorded & ~consumed & ~watch_set & ~watch_drop) | hit; // RQ9 RQ12
  wire [N_THREADS-1:0] next_watching =
    (watching | watch_set) & ~watch_drop; // RQ11 RQ23
  wire [N_THREADS-1:0] next_waiting =
    (waiting & ~sent & ~exit_vec) | wait_start; // RQ10
  wire [N_THREADS-1:0] next_pre_hit =
    (pre_hit | pre_now) & ~sent & ~exit_vec; // RQ16

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recorded <= '0;
      watching <= '0;
      waiting <= '0;
      pre_hit <= '0;
    end else begin
      recorded <= next_recorded;
      watching <= next_watching;
      waiting <= next_waiting;
      pre_hit <= next_pre_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N_THREADS; i++) begin
        watch_num[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N_THREADS; i++) begin
        if (watch_set[i]) begin
          watch_num[i] <= evt_in; // RQ11
        end
      end
    end
  end

  // ==========================================================
  // Link outputs
  // ==========================================================
  // Ready drops for one cycle after a completion so that the next
  // barrier round never overlaps the broadcast of the last one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.msg_ready <= 1'b0;
      link.wb_valid <= 1'b0;
      link.wb_threads <= '0;
      link.wb_done <= 1'b0;
      link.wb_write <= 1'b0;
      link.wb_data <= '0;
    end else begin
      link.msg_ready <= ~bar_fire;
      link.wb_valid <= next_wb_valid;
      link.wb_threads <= next_wb_threads;
      link.wb_done <= bar_fire; // RQ1
      link.wb_write <= next_wb_write;
      link.wb_data <= next_wb_data;
    end
  end

endmodule : sgw_hub

// ==== hw/sgw_wait_timer.sv ====
`timescale 1ns/1ps

module sgw_wait_timer #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic tick,
  input wire logic start,
  input wire logic cancel,
  input wire logic [W-1:0] units,
  // Status
  output logic expired
);

  logic [W-1:0] count;
  logic run;
  wire last = (count <= W'(1));

  // ==========================================================
  // Unit countdown
  // ==========================================================
  // The tick phase is free running, so the first unit is partial and
  // the wait lands between units-1 and units whole units.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      run <= 1'b0;
      expired <= 1'b0;
    end else if (start) begin
      count <= units;
      run <= 1'b1;
      expired <= 1'b0;
    end else if (cancel) begin
      run <= 1'b0;
      expired <= 1'b0;
    end else if (run && tick) begin
      count <= last ? count : count - W'(1);
      run <= !last;
      expired <= last;
    end
  end

endmodule : sgw_wait_timer

// ==== inc/sgw_link_if.sv ====
`timescale 1ns/1ps

interface sgw_link_if #(
  parameter int N_THREADS = 8
);
  localparam int TW = (N_THREADS > 1) ? $clog2(N_THREADS) : 1;

  // ==========================================================
  // Messages from the core to the hub
  // ==========================================================
  logic msg_valid;
  logic msg_ready;
  sgw_pkg::sgw_msg_e msg_kind;
  logic [TW-1:0] msg_thread;
  logic [31:0] msg_dw0;
  logic [15:0] msg_mask;
  logic [3:0] msg_rlen;

  // ==========================================================
  // Writebacks from the hub to the core
  // ==========================================================
  logic wb_valid;
  logic [N_THREADS-1:0] wb_threads;
  logic wb_done;
  logic wb_write;
  logic [15:0] wb_data;

  modport hub (
    input msg_valid, msg_kind, msg_thread, msg_dw0, msg_mask, msg_rlen,
    output msg_ready, wb_valid, wb_threads, wb_done, wb_write, wb_data
  );

  modport core (
    output msg_valid, msg_kind, msg_thread, msg_dw0, msg_mask, msg_rlen,
    input msg_ready, wb_valid, wb_threads, wb_done, wb_write, wb_data
  );

endinterface : sgw_link_if

// ==== inc/sgw_params.svh ====
`ifndef SGW_PARAMS_SVH
`define SGW_PARAMS_SVH

// ==========================================================
// Message payload fields
// ==========================================================
`define SGW_EVT_MSB 23
`define SGW_TMO_MSB 9
`define SGW_TMO_MIN 10'h002
`define SGW_PRED_BIT 23
`define SGW_CNTEN_BIT 15
`define SGW_CNT_MSB 14
`define SGW_CNT_LSB 8
`define SGW_MASK_W 16
`define SGW_WB_W 16
`define SGW_WB_OCC 16'h0001
`define SGW_WB_NONE 16'h0000
`define SGW_RLEN_ONE 4'h1
`define SGW_RLEN_NONE 4'h0

// ==========================================================
// Timing and reset values
// ==========================================================
`define SGW_TICK_CYCLES 1024
`define SGW_LIMIT_RST 7'h01

// ==========================================================
// Register map of the core port
// ==========================================================
`define SGW_REG_CTRL 12'h000
`define SGW_REG_PAYLOAD 12'h004
`define SGW_REG_STATUS 12'h008
`define SGW_REG_DONE 12'h00C
`define SGW_TRF_PAGE 6'h01
`define SGW_CTRL_THR_LSB 8
`define SGW_CTRL_MASK_LSB 16
`define SGW_ST_BUSY 0
`define SGW_ST_ERR 1

`endif

// ==== inc/sgw_pkg.sv ====
package sgw_pkg;

  // Message kinds carried on the link.
  typedef enum logic [2:0] {
    msg_barrier,
    msg_watch,
    msg_wait,
    msg_raise,
    msg_unwatch,
    msg_exit
  } sgw_msg_e;

endpackage : sgw_pkg

// ==== test/sgw_link_props.sv ====
`timescale 1ns/1ps
`include "sgw_params.svh"

module sgw_link_props #(
  parameter int N_THREADS = 8,
  parameter int TICK_CYCLES = `SGW_TICK_CYCLES,
  parameter int TW = (N_THREADS > 1) ? $clog2(N_THREADS) : 1
) (
  // Clock, reset and engine
  input wire logic pclk,
  input wire logic presetn,
  input wire logic preempt,
  // Link signals
  input wire logic msg_valid,
  input wire logic msg_ready,
  input wire sgw_pkg::sgw_msg_e msg_kind,
  input wire logic [TW-1:0] msg_thread,
  input wire logic [31:0] msg_dw0,
  input wire logic [3:0] msg_rlen,
  input wire logic wb_valid,
  input wire logic [N_THREADS-1:0] wb_threads,
  input wire logic wb_done,
  input wire logic wb_write,
  input wire logic [15:0] wb_data
);
  // ==========================================================
  // Tracking of the last accepted wait
  // ==========================================================
  // Only one wait is followed at a time, which keeps this small.
  logic on;
  logic [TW-1:0] thr;
  logic [9:0] tmo;
  int cnt;
  wire take_w = msg_valid && msg_ready && msg_kind == sgw_pkg::msg_wait;
  wire take_b = msg_valid && msg_ready && msg_kind == sgw_pkg::msg_barrier;
  wire mine = wb_valid && !wb_done && wb_threads[thr];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on <= 1'b0;
      thr <= '0;
      tmo <= 10'h000;
      cnt <= 0;
    end else if (take_w) begin
      on <= 1'b1;
      thr <= msg_thread;
      tmo <= msg_dw0[`SGW_TMO_MSB:0];
      cnt <= 0;
    end else begin
      on <= on && !mine && !preempt;
      cnt <= cnt + 1;
    end
  end

  // ==========================================================
  // Properties
  // ==========================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_stall_once;
    !msg_ready ##1 msg_ready;
  endsequence

  sequence s_same_msg;
    msg_valid && $stable(msg_kind) && $stable(msg_thread)
      && $stable(msg_dw0);
  endsequence

  msg_hold_a: assert property (msg_valid && !msg_ready |=> s_same_msg)
    else $error("link message changed before it was taken");
  done_take_a: assert property (wb_valid && wb_done |-> $past(take_b))
    else $error("completion without a barrier arrival");
  done_stall_a: assert property (wb_valid && wb_done |-> s_stall_once)
    else $error("ready not low for one cycle at completion");
  pred_write_a: assert property (wb_valid && wb_done |->
    wb_write == $past(msg_dw0[`SGW_PRED_BIT]))
    else $error("sum write does not follow predication");
  evt_word_a: assert property (wb_valid && !wb_done |->
    wb_write && wb_data[15:1] == 15'h0000)
    else $error("event writeback word malformed");
  wb_target_a: assert property (wb_valid |-> wb_threads != '0)
    else $error("writeback with no target thread");
  wait_upper_a: assert property (on |->
    cnt <= int'(tmo) * TICK_CYCLES + 2)
    else $error("wait outlived its timeout");
  wait_lower_a: assert property (mine && on && !wb_data[0] |->
    cnt >= (int'(tmo) - 1) * TICK_CYCLES)
    else $error("timeout writeback came too early");
  preempt_wb_a: assert property (preempt && on |-> ##[1:8] mine)
    else $error("preemption left a wait unanswered");
  rlen_one_a: assert property (msg_valid && msg_dw0[`SGW_PRED_BIT] &&
    msg_kind == sgw_pkg::msg_barrier |-> msg_rlen == `SGW_RLEN_ONE)
    else $error("predicated barrier without length one");
endmodule : sgw_link_props

// ==== test/thread_sync_gateway_events_tb.sv ====
`timescale 1ns/1ps
`include "sgw_params.svh"

module thread_sync_gateway_events_tb;
  localparam int NT = 4;
  localparam int TICK = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic preempt = 1'b0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic [NT-1:0] done_flags;
  logic [NT-1:0] waiting;
  logic [NT-1:0] watching;
  logic [31:0] rdat;
  logic rerr;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;

  sgw_link_if #(.N_THREADS(NT)) link ();
  sgw_hub #(.N_THREADS(NT), .TICK_CYCLES(TICK)) sgw_hub_i (
    .pclk(pclk), .presetn(presetn), .link(link), .preempt(preempt),
    .waiting(waiting), .watching(watching));
  sgw_core_port #(.N_THREADS(NT)) sgw_core_port_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .link(link),
    .done_flags(done_flags));
  sgw_link_props #(.N_THREADS(NT), .TICK_CYCLES(TICK)) sgw_link_props_i (
    .pclk(pclk), .presetn(presetn), .preempt(preempt),
    .msg_valid(link.msg_valid), .msg_ready(link.msg_ready),
    .msg_kind(link.msg_kind), .msg_thread(link.msg_thread),
    .msg_dw0(link.msg_dw0), .msg_rlen(link.msg_rlen),
    .wb_valid(link.wb_valid),
    .wb_threads(link.wb_threads), .wb_done(link.wb_done),
    .wb_write(link.wb_write), .wb_data(link.wb_data));

  always #50 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ==========================================================
  // Access tasks
  // ==========================================================
  task automatic end_of_test();
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic ck(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : ck

  // The request stands until pready is sampled high at a rising edge;
  // one idle edge follows so the next setup never reuses this step.
  task automatic xf(input logic wr, input logic [11:0] a,
                    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xf

  function automatic logic [11:0] tr(input int i);
    return 12'h040 + 12'(4 * i);
  endfunction : tr

  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    xf(1'b0, a, 32'h00000000);
    ck(rdat, exp);
  endtask : rc

  task automatic snd(input sgw_pkg::sgw_msg_e k, input int t,
                     input logic [31:0] dw0, input logic [15:0] m);
    xf(1'b1, `SGW_REG_PAYLOAD, dw0);
    xf(1'b1, `SGW_REG_CTRL, {m, 5'h00, 3'(t), 5'h00, 3'(k)});
    do begin
      xf(1'b0, `SGW_REG_STATUS, 32'h00000000);
    end while (rdat[`SGW_ST_BUSY] === 1'b1);
  endtask : snd

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(`SGW_REG_DONE, 32'h00000000);
    xf(1'b0, 12'h020, 32'h00000000);
    ck(32'(rerr), 32'h00000001);
    // The barrier limit comes out of reset at one.
    xf(1'b1, tr(0), 32'h12345678);
    snd(sgw_pkg::msg_barrier, 0, 32'h00000000, 16'hFFFF);
    rc(`SGW_REG_DONE, 32'h00000001);
    rc(tr(0), 32'h12345678);
    xf(1'b1, `SGW_REG_DONE, 32'h0000000F);
    for (int i = 1; i < NT; i++) begin
      xf(1'b1, tr(i), 32'hA5A5FFFF);
    end
    snd(sgw_pkg::msg_barrier, 1, 32'h00808300, 16'h00FF);
    snd(sgw_pkg::msg_barrier, 2, 32'h00808300, 16'h0F0F);
    rc(`SGW_REG_DONE, 32'h00000000);
    snd(sgw_pkg::msg_barrier, 3, 32'h00808300, 16'h8001);
    ck(32'(done_flags), 32'h0000000E);
    for (int i = 1; i < NT; i++) begin
      rc(tr(i), 32'hA5A50012);
    end
    for (int i = 0; i < NT; i++) begin
      xf(1'b1, tr(i), 32'hFFFFFFFF);
    end
    snd(sgw_pkg::msg_watch, 0, 32'hFF00ABCD, 16'h0000);
    snd(sgw_pkg::msg_raise, 1, 32'h7700ABCD, 16'h0000);
    rc(tr(0), 32'hFFFFFFFF);
    snd(sgw_pkg::msg_wait, 0, 32'hFFFFFC64, 16'h0000);
    rc(tr(0), 32'hFFFF0001);
    xf(1'b1, tr(0), 32'hFFFFFFFF);
    snd(sgw_pkg::msg_watch, 0, 32'h00000005, 16'h0000);
    snd(sgw_pkg::msg_raise, 1, 32'h00000005, 16'h0000);
    snd(sgw_pkg::msg_watch, 0, 32'h00000006, 16'h0000);
    snd(sgw_pkg::msg_raise, 1, 32'h00000005, 16'h0000);
    snd(sgw_pkg::msg_wait, 0, 32'h00000003, 16'h0000);
    rc(tr(0), 32'hFFFFFFFF);
    repeat (40) @(posedge pclk);
    rc(tr(0), 32'hFFFF0000);
    snd(sgw_pkg::msg_watch, 2, 32'h00000009, 16'h0000);
    snd(sgw_pkg::msg_watch, 3, 32'h00000009, 16'h0000);
    snd(sgw_pkg::msg_wait, 2, 32'h000003FF, 16'h0000);
    ck(32'(waiting), 32'h00000004);
    snd(sgw_pkg::msg_raise, 1, 32'h00000009, 16'h0000);
    rc(tr(2), 32'hFFFF0001);
    rc(tr(3), 32'hFFFFFFFF);
    snd(sgw_pkg::msg_wait, 3, 32'h000003FF, 16'h0000);
    rc(tr(3), 32'hFFFF0001);
    ck(32'(waiting), 32'h00000000);
    snd(sgw_pkg::msg_watch, 1, 32'h00000007, 16'h0000);
    snd(sgw_pkg::msg_wait, 1, 32'h000003FF, 16'h0000);
    preempt <= 1'b1;
    @(posedge pclk);
    preempt <= 1'b0;
    repeat (4) @(posedge pclk);
    rc(tr(1), 32'hFFFF0000);
    xf(1'b1, tr(3), 32'hFFFFFFFF);
    snd(sgw_pkg::msg_watch, 3, 32'h00000008, 16'h0000);
    snd(sgw_pkg::msg_exit, 3, 32'h00000000, 16'h0000);
    snd(sgw_pkg::msg_unwatch, 0, 32'h00000000, 16'h0000);
    ck(32'(watching), 32'h00000006);
    snd(sgw_pkg::msg_raise, 1, 32'h00000008, 16'h0000);
    snd(sgw_pkg::msg_wait, 3, 32'h00000002, 16'h0000);
    repeat (30) @(posedge pclk);
    rc(tr(3), 32'hFFFF0000);
    // Timeouts of zero and one must be turned away at the port.
    for (int t = 0; t < 2; t++) begin
      xf(1'b1, `SGW_REG_PAYLOAD, 32'(t));
      xf(1'b1, `SGW_REG_CTRL, 32'(3'(sgw_pkg::msg_wait)));
      ck(32'(rerr), 32'h00000001);
      rc(`SGW_REG_STATUS, 32'h00000002);
      xf(1'b1, `SGW_REG_STATUS, 32'h00000002);
    end
    rc(`SGW_REG_STATUS, 32'h00000000);
    rc(`SGW_REG_CTRL, 32'h00000302);
    rc(`SGW_REG_PAYLOAD, 32'h00000001);
    end_of_test();
  end
endmodule : thread_sync_gateway_events_tb
